// ==== opdv_pkg.sv ====
// Purpose: Shared constants for the pop reduction and DAC volume bank
// Assumes: 125 MHz ref_clk; register index times four is the byte address
// Notes: Delay figures are kept in microseconds and scaled at run time
package opdv_pkg;

    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned US_PER_MS = 1000;
    localparam int unsigned US_TICK_CYCLES = NS_PER_US / CLK_PERIOD_NS;

    localparam logic [7:0] IDX_LINK = 8'h29;
    localparam logic [7:0] IDX_POP = 8'h2A;
    localparam logic [7:0] IDX_LVOL = 8'h2B;
    localparam logic [7:0] IDX_RVOL = 8'h2C;
    localparam logic [7:0] IDX_CTRL = 8'h30;
    localparam logic [9:0] ADDR_LINK = {IDX_LINK, 2'b00};
    localparam logic [9:0] ADDR_POP = {IDX_POP, 2'b00};
    localparam logic [9:0] ADDR_LVOL = {IDX_LVOL, 2'b00};
    localparam logic [9:0] ADDR_RVOL = {IDX_RVOL, 2'b00};
    localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};

    localparam logic [7:0] POP_RST = 8'h00;
    localparam logic [7:0] VOL_RST = 8'h80;
    localparam logic [1:0] LINK_RST = 2'h0;

    localparam int unsigned POP_CM_BIT = 1;
    localparam int unsigned VOL_MUTE_BIT = 7;
    localparam int unsigned CTRL_UP_BIT = 0;
    localparam int unsigned CTRL_DN_BIT = 1;

    localparam logic [1:0] LINK_L_FOLLOWS_R = 2'h1;
    localparam logic [1:0] LINK_R_FOLLOWS_L = 2'h2;

    localparam int unsigned RAMP_STEPS = 8;

    // Power-on delay per code, in microseconds
    localparam int unsigned DLY_US [0:11] = '{
        0, 10, 100, 1000, 10000, 50000, 100000,
        200000, 400000, 800000, 2000000, 4000000
    };
    // Ramp step time per code, in milliseconds
    localparam int unsigned STEP_MS [0:3] = '{0, 1, 2, 4};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_RAMP = 2'b11
    } opdv_state_t;

    function automatic logic [21:0] dly_us(input logic [3:0] code);
        // Reserved codes fall back to the longest delay
        if (code > 4'hB) begin
            return 22'(DLY_US[11]);
        end
        return 22'(DLY_US[code]);
    endfunction

    function automatic logic [21:0] step_us(input logic [1:0] code);
        return 22'(STEP_MS[code] * US_PER_MS);
    endfunction

endpackage

// ==== opdv_timer.sv ====
// Purpose: Microsecond interval timer shared by delay and ramp steps
// Assumes: start is a one-cycle pulse from same-clock logic
// Notes: A new start reloads the timer even while it is running
`timescale 1ns/1ns
module opdv_timer #(
    parameter int unsigned TICK_CYCLES = 125
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [21:0] count_us,
    output logic done
);

    typedef struct packed {
        logic [21:0] cnt;
        logic [15:0] pre;
        logic busy;
        logic done;
    } opdv_tmr_t;

    opdv_tmr_t r;
    opdv_tmr_t next_r;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (start) begin
            next_r.pre = 16'h0000;
            next_r.cnt = count_us;
            next_r.busy = (count_us != 22'h000000);
            next_r.done = (count_us == 22'h000000);
        end else if (r.busy) begin
            if (r.pre == 16'(TICK_CYCLES - 1)) begin
                next_r.pre = 16'h0000;
                if (r.cnt == 22'h000001) begin
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                end
                next_r.cnt = r.cnt - 22'h000001;
            end else begin
                next_r.pre = r.pre + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;

endmodule

// ==== opdv_top.sv ====
// Purpose: Pop reduction and DAC digital volume registers on AHB-Lite
// Assumes: Single word transfers; slave always ready with OKAY response
// Notes: Volume outputs already apply the channel linking setting
// Function
// [RULE1] Bits 7:4 pick driver power-on delay, 0 us up to 4 s, reset 0.
// [RULE2] Software must not write delay codes 1100 to 1111.
// [RULE3] Bits 3:2 pick ramp step time 0, 1, 2 or 4 ms, reset 0.
// [RULE4] Bit 1 picks weak common-mode source: divider or bandgap, reset 0.
// [RULE5] Software writes zero to pop register bit 0.
// [RULE6] Left volume bit 7 mutes left channel; resets muted.
// [RULE7] Left bits 6:0 attenuate in 0.5 dB steps, reset 0 dB.
// [RULE8] Right volume bit 7 mutes right channel; resets muted.
// [RULE9] Right bits 6:0 attenuate in 0.5 dB steps, reset 0 dB.
// [RULE10] Link code 01 makes left follow right, 10 right follow left.
// [RULE11] Delays counted from reference clock; new codes apply next sequence.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
module opdv_top #(
    parameter int unsigned TICK_CYCLES = opdv_pkg::US_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic left_mute,
    output logic [6:0] left_atten,
    output logic right_mute,
    output logic [6:0] right_atten,
    output logic weak_cm_bandgap,
    output logic driver_on,
    output logic ramp_step,
    output logic seq_busy
);

    typedef struct packed {
        logic [7:0] pop;
        logic [7:0] lvol;
        logic [7:0] rvol;
        logic [1:0] link;
        logic wr_pend;
        logic [9:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        opdv_pkg::opdv_state_t st;
        logic [3:0] steps_left;
        logic [21:0] step_us;
        logic [21:0] tmr_cnt;
        logic tmr_start;
        logic drv_on;
        logic ramp_step;
        logic busy;
        logic left_mute;
        logic [6:0] left_att;
        logic right_mute;
        logic [6:0] right_att;
        logic weak_cm;
    } opdv_regs_t;

    localparam opdv_regs_t REGS_RST = '{
        pop: opdv_pkg::POP_RST,
        lvol: opdv_pkg::VOL_RST,
        rvol: opdv_pkg::VOL_RST,
        link: opdv_pkg::LINK_RST,
        hreadyout: 1'b1,
        left_mute: opdv_pkg::VOL_RST[opdv_pkg::VOL_MUTE_BIT],
        right_mute: opdv_pkg::VOL_RST[opdv_pkg::VOL_MUTE_BIT],
        st: opdv_pkg::ST_IDLE,
        default: '0
    };

    opdv_regs_t r;
    opdv_regs_t next_r;
    logic tmr_done;
    logic access;
    logic in_map;
    logic up_req;
    logic dn_req;
    logic [7:0] left_src;
    logic [7:0] right_src;

    // Upper address bits must be zero, so the bank does not alias
    assign in_map = (haddr[31:10] == 22'h000000);
    assign access = hsel && htrans[1] && hready;
    assign up_req = r.wr_pend && (r.wr_addr == opdv_pkg::ADDR_CTRL)
                    && hwdata[opdv_pkg::CTRL_UP_BIT];
    assign dn_req = r.wr_pend && (r.wr_addr == opdv_pkg::ADDR_CTRL)
                    && hwdata[opdv_pkg::CTRL_DN_BIT];

    opdv_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(r.tmr_start),
        .count_us(r.tmr_cnt),
        .done(tmr_done)
    );

    always_comb begin
        next_r = r;
        next_r.tmr_start = 1'b0;
        next_r.ramp_step = 1'b0;

        // Data phase of a write lands in the register file
        if (r.wr_pend) begin
            if (r.wr_addr == opdv_pkg::ADDR_POP) begin
                next_r.pop = hwdata[7:0]; // [RULE1] [RULE3] [RULE4]
            end else if (r.wr_addr == opdv_pkg::ADDR_LVOL) begin
                next_r.lvol = hwdata[7:0]; // [RULE6] [RULE7]
            end else if (r.wr_addr == opdv_pkg::ADDR_RVOL) begin
                next_r.rvol = hwdata[7:0]; // [RULE8] [RULE9]
            end else if (r.wr_addr == opdv_pkg::ADDR_LINK) begin
                next_r.link = hwdata[1:0]; // [RULE10]
            end
        end
        next_r.wr_pend = access && hwrite && in_map;
        next_r.wr_addr = haddr[9:0];

        // Codes are sampled only when a sequence starts
        case (r.st)
            opdv_pkg::ST_IDLE: begin
                if (up_req) begin
                    next_r.step_us = opdv_pkg::step_us(r.pop[3:2]); // [RULE3]
                    // Reserved codes clamp to the longest delay [RULE2]
                    next_r.tmr_cnt = opdv_pkg::dly_us(r.pop[7:4]); // [RULE1]
                    next_r.tmr_start = 1'b1; // [RULE11]
                    next_r.drv_on = 1'b0;
                    next_r.st = opdv_pkg::ST_DELAY;
                end
            end
            opdv_pkg::ST_DELAY: begin
                if (tmr_done) begin
                    next_r.drv_on = 1'b1;
                    next_r.steps_left = 4'(opdv_pkg::RAMP_STEPS);
                    next_r.tmr_cnt = r.step_us; // [RULE11]
                    next_r.tmr_start = 1'b1;
                    next_r.st = opdv_pkg::ST_RAMP;
                end
            end
            opdv_pkg::ST_RAMP: begin
                if (tmr_done) begin
                    next_r.ramp_step = 1'b1;
                    if (r.steps_left == 4'h1) begin
                        next_r.st = opdv_pkg::ST_IDLE;
                    end else begin
                        next_r.steps_left = r.steps_left - 4'h1;
                        next_r.tmr_cnt = r.step_us; // [RULE3]
                        next_r.tmr_start = 1'b1;
                    end
                end
            end
            default: begin
                next_r.st = opdv_pkg::ST_IDLE;
            end
        endcase

        // Power-down wins over any sequence step in the same cycle
        if (dn_req) begin
            next_r.st = opdv_pkg::ST_IDLE;
            next_r.drv_on = 1'b0;
            next_r.tmr_start = 1'b0;
            next_r.ramp_step = 1'b0;
        end
        next_r.busy = (next_r.st != opdv_pkg::ST_IDLE);

        // Read data uses the updated copy, so a read right after a
        // write to the same register sees the new value
        next_r.hrdata = 32'h00000000;
        if (access && !hwrite && in_map) begin
            if (haddr[9:0] == opdv_pkg::ADDR_POP) begin
                next_r.hrdata = {24'h000000, next_r.pop};
            end else if (haddr[9:0] == opdv_pkg::ADDR_LVOL) begin
                next_r.hrdata = {24'h000000, next_r.lvol};
            end else if (haddr[9:0] == opdv_pkg::ADDR_RVOL) begin
                next_r.hrdata = {24'h000000, next_r.rvol};
            end else if (haddr[9:0] == opdv_pkg::ADDR_LINK) begin
                next_r.hrdata = {30'h00000000, next_r.link};
            end else if (haddr[9:0] == opdv_pkg::ADDR_CTRL) begin
                next_r.hrdata = {28'h0000000, next_r.st,
                                 next_r.drv_on, next_r.busy};
            end
        end

        // Channel linking picks which register drives each DAC
        left_src = next_r.lvol;
        right_src = next_r.rvol;
        if (next_r.link == opdv_pkg::LINK_L_FOLLOWS_R) begin
            left_src = next_r.rvol; // [RULE10]
        end
        if (next_r.link == opdv_pkg::LINK_R_FOLLOWS_L) begin
            right_src = next_r.lvol; // [RULE10]
        end
        next_r.left_mute = left_src[opdv_pkg::VOL_MUTE_BIT]; // [RULE6]
        next_r.left_att = left_src[6:0]; // [RULE7]
        next_r.right_mute = right_src[opdv_pkg::VOL_MUTE_BIT]; // [RULE8]
        next_r.right_att = right_src[6:0]; // [RULE9]
        next_r.weak_cm = next_r.pop[opdv_pkg::POP_CM_BIT]; // [RULE4]
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            r <= REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0 & r.hreadyout;
    assign hrdata = r.hrdata;
    assign left_mute = r.left_mute;
    assign left_atten = r.left_att;
    assign right_mute = r.right_mute;
    assign right_atten = r.right_att;
    assign weak_cm_bandgap = r.weak_cm;
    assign driver_on = r.drv_on;
    assign ramp_step = r.ramp_step;
    assign seq_busy = r.busy;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_delay_code_load: assert property ( // [RULE1]
        (r.st == opdv_pkg::ST_IDLE && up_req && !dn_req)
        |=> (r.tmr_cnt == opdv_pkg::dly_us($past(r.pop[7:4])))
            && r.tmr_start)
        else $error("power-on delay not loaded from delay code");

    a_step_code_load: assert property ( // [RULE3]
        (r.st == opdv_pkg::ST_IDLE && up_req && !dn_req)
        |=> r.step_us == opdv_pkg::step_us($past(r.pop[3:2])))
        else $error("ramp step time not loaded from step code");

    a_zero_step_pace: assert property ( // [RULE3]
        (r.st == opdv_pkg::ST_RAMP && r.tmr_start
         && r.step_us == 22'h000000)
        |-> ##2 (ramp_step || !driver_on))
        else $error("zero step time did not step two cycles later");

    a_cm_source_sel: assert property ( // [RULE4]
        (r.wr_pend && r.wr_addr == opdv_pkg::ADDR_POP)
        |=> weak_cm_bandgap == $past(hwdata[opdv_pkg::POP_CM_BIT]))
        else $error("weak common-mode select did not follow write");

    a_left_mute_own: assert property ( // [RULE6]
        (r.link != opdv_pkg::LINK_L_FOLLOWS_R)
        |-> left_mute == r.lvol[opdv_pkg::VOL_MUTE_BIT])
        else $error("left mute differs from left volume register");

    a_left_atten_wr: assert property ( // [RULE7]
        (r.wr_pend && r.wr_addr == opdv_pkg::ADDR_LVOL
         && r.link != opdv_pkg::LINK_L_FOLLOWS_R)
        |=> left_atten == $past(hwdata[6:0]))
        else $error("left attenuation did not follow write");

    a_right_mute_own: assert property ( // [RULE8]
        (r.link != opdv_pkg::LINK_R_FOLLOWS_L)
        |-> right_mute == r.rvol[opdv_pkg::VOL_MUTE_BIT])
        else $error("right mute differs from right volume register");

    a_right_atten_wr: assert property ( // [RULE9]
        (r.wr_pend && r.wr_addr == opdv_pkg::ADDR_RVOL
         && r.link != opdv_pkg::LINK_R_FOLLOWS_L)
        |=> right_atten == $past(hwdata[6:0]))
        else $error("right attenuation did not follow write");

    a_link_left_follow: assert property ( // [RULE10]
        (r.link == opdv_pkg::LINK_L_FOLLOWS_R)
        |-> {left_mute, left_atten} == r.rvol
            && {right_mute, right_atten} == r.rvol)
        else $error("left channel not following right register");

    a_link_right_follow: assert property ( // [RULE10]
        (r.link == opdv_pkg::LINK_R_FOLLOWS_L)
        |-> {left_mute, left_atten} == r.lvol
            && {right_mute, right_atten} == r.lvol)
        else $error("right channel not following left register");

    // Power-down must win at once, whatever state the sequence is in
    a_power_down: assert property ( // [RULE11]
        dn_req |=> !driver_on && !seq_busy && !ramp_step)
        else $error("power-down did not stop the driver sequence");

    a_driver_on_seq: assert property ( // [RULE11]
        (r.st == opdv_pkg::ST_DELAY && tmr_done && !dn_req)
        |=> driver_on && r.st == opdv_pkg::ST_RAMP)
        else $error("driver not enabled when power-on delay expired");

    a_ramp_end: assert property ( // [RULE11]
        (r.st == opdv_pkg::ST_RAMP && tmr_done
         && r.steps_left == 4'h1 && !dn_req)
        |=> ramp_step && !seq_busy ##1 !ramp_step)
        else $error("ramp did not finish after last step");

    c_full_sequence: cover property (
        r.st == opdv_pkg::ST_DELAY ##1 r.st == opdv_pkg::ST_RAMP);
    c_ramp_done: cover property (ramp_step && !seq_busy && driver_on);
    c_link_right: cover property (
        r.link == opdv_pkg::LINK_R_FOLLOWS_L && !right_mute);
    c_power_down: cover property (dn_req && seq_busy);

endmodule

// ==== opdv_top_tb_top.sv ====
// Purpose: Self-checking bench for the pop reduction and volume bank
// Assumes: TICK_CYCLES of 1, so one delay microsecond is one cycle
// Notes: Delay code 1011 is only started and then aborted; codes 0100 to 1010 are not run
`timescale 1ns/1ns
`define CHK(got, want) begin \
    comparisons++; \
    if ((got) !== (want)) begin \
        error_cnt++; \
        $display("unexpected at %0t: got %0h want %0h", $time, got, want); \
    end \
end
module opdv_top_tb_top;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, left_mute, right_mute;
    logic weak_cm_bandgap, driver_on, ramp_step, seq_busy;
    logic [31:0] hrdata;
    logic [6:0] left_atten, right_atten;
    int error_cnt = 0;
    int comparisons = 0;
    localparam logic [31:0] A_LINK = 32'(opdv_pkg::ADDR_LINK);
    localparam logic [31:0] A_POP = 32'(opdv_pkg::ADDR_POP);
    localparam logic [31:0] A_LVOL = 32'(opdv_pkg::ADDR_LVOL);
    localparam logic [31:0] A_RVOL = 32'(opdv_pkg::ADDR_RVOL);
    localparam logic [31:0] A_CTRL = 32'(opdv_pkg::ADDR_CTRL);

    always #4 ref_clk = ~ref_clk;

    opdv_top #(.TICK_CYCLES(1)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .left_mute(left_mute), .left_atten(left_atten),
        .right_mute(right_mute), .right_atten(right_atten),
        .weak_cm_bandgap(weak_cm_bandgap), .driver_on(driver_on),
        .ramp_step(ramp_step), .seq_busy(seq_busy)
    );

    task automatic results();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Waits for hready at an edge; a stuck slave ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            results();
        end
    endtask

    // Called at a rising edge; drives address then data phase
    task automatic bus(input logic wr, input logic [31:0] a,
            input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        `CHK({left_mute, left_atten}, 8'h80)
        `CHK({right_mute, right_atten}, 8'h80)
        `CHK(weak_cm_bandgap, 1'b0)
        `CHK({driver_on, seq_busy, ramp_step}, 3'h0)
        rd_chk(A_POP, 32'h00);
        rd_chk(A_LVOL, 32'h80);
        rd_chk(A_RVOL, 32'h80);
        rd_chk(A_LINK, 32'h0);
    endtask

    task automatic t_pop();
        wr(A_POP, 32'hBE);
        rd_chk(A_POP, 32'hBE);
        settle();
        `CHK(weak_cm_bandgap, 1'b1)
        wr(A_POP, 32'h00);
        settle();
        `CHK(weak_cm_bandgap, 1'b0)
        // Unmapped and out-of-range addresses read zero, writes dropped
        wr(32'h100, 32'hFF);
        rd_chk(32'h100, 32'h0);
        rd_chk(A_POP | 32'h400, 32'h0);
    endtask

    task automatic t_vol();
        logic [7:0] lv, rv, el, er;
        lv = 8'h7F;
        rv = 8'hFE;
        wr(A_LVOL, 32'(lv));
        rd_chk(A_LVOL, 32'h7F);
        wr(A_RVOL, 32'(rv));
        rd_chk(A_RVOL, 32'hFE);
        for (int c = 0; c < 4; c++) begin
            wr(A_LINK, 32'(c));
            settle();
            el = (c == 1) ? rv : lv;
            er = (c == 2) ? lv : rv;
            `CHK({left_mute, left_atten}, el)
            `CHK({right_mute, right_atten}, er)
        end
        wr(A_LINK, 32'h0);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (seq_busy !== 1'b0 && n < 40000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 40000) begin
            error_cnt++;
            results();
        end
    endtask

    // Counts edges until driver_on (sel 0) or ramp_step reads high
    task automatic wait_hi(input int sel, input int lim, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while ((sel == 0 ? driver_on : ramp_step) !== 1'b1 && n < lim);
        if ((sel == 0 ? driver_on : ramp_step) !== 1'b1) begin
            error_cnt++;
            results();
        end
    endtask

    task automatic t_delay();
        int dly[4] = '{0, 10, 100, 1000};
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(A_POP, 32'(c << 4));
            wr(A_CTRL, 32'h1);
            wait_hi(0, 1100, n);
            `CHK(n >= dly[c] + 1 && n <= dly[c] + 8, 1'b1)
            wait_idle();
            wr(A_CTRL, 32'h2);
        end
    endtask

    // A pop write right after start must not change the running steps
    task automatic t_step();
        int st[4] = '{0, 1000, 2000, 4000};
        int n;
        int k;
        for (int c = 0; c < 4; c++) begin
            wr(A_POP, 32'(c << 2));
            wr(A_CTRL, 32'h1);
            wr(A_POP, 32'h0);
            wait_hi(1, 5000, n);
            wait_hi(1, 5000, n);
            `CHK(n >= st[c] + 1 && n <= st[c] + 3, 1'b1)
            k = 2;
            n = 0;
            while (seq_busy === 1'b1 && n < 40000) begin
                @(posedge ref_clk);
                n++;
                if (ramp_step === 1'b1) begin
                    k++;
                end
            end
            if (n >= 40000) begin
                error_cnt++;
                results();
            end
            `CHK(k, int'(opdv_pkg::RAMP_STEPS))
            `CHK(ramp_step, 1'b1)
            wr(A_CTRL, 32'h2);
            settle();
            `CHK(driver_on, 1'b0)
        end
    endtask

    // Power-down in the middle of a long delay aborts the sequence
    task automatic t_abort();
        wr(A_POP, 32'hB0);
        wr(A_CTRL, 32'h1);
        rd_chk(A_CTRL, 32'h5);
        wr(A_CTRL, 32'h2);
        settle();
        `CHK({driver_on, seq_busy}, 2'h0)
        rd_chk(A_CTRL, 32'h0);
        wr(A_POP, 32'h00);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        @(posedge ref_clk);
        t_reset();
        t_pop();
        t_vol();
        t_delay();
        t_step();
        t_abort();
        results();
    end
endmodule
